// ==== logic/flash_host_map.vh ====
// timing and field constants for the parallel flash host controller
// assumes a 100 MHz controller clock; counts derive from times in ns
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH

`define CLK_PERIOD_NS        10
// address access time and chip-select access time (plain defaults)
`define ADDR_ACCESS_NS       70
`define CE_ACCESS_NS         70
// automatic sleep margin beyond address access time
`define SLEEP_MARGIN_NS      30
`define RESET_PULSE_NS       500
`define RESET_HIGH_READ_NS   50
`define RESET_READY_EMB_NS   20000
`define RESET_READY_NON_NS   500
`define WRITE_PULSE_NS       40
// least times round up
`define CEIL_CYC(t)          (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC             `CEIL_CYC(`CE_ACCESS_NS)
`define SLEEP_CYC            `CEIL_CYC(`ADDR_ACCESS_NS + `SLEEP_MARGIN_NS)
`define RESET_PULSE_CYC      `CEIL_CYC(`RESET_PULSE_NS)
`define RESET_HIGH_READ_CYC  `CEIL_CYC(`RESET_HIGH_READ_NS)
`define RESET_READY_NON_CYC  `CEIL_CYC(`RESET_READY_NON_NS)
`define WRITE_CYC            `CEIL_CYC(`WRITE_PULSE_NS)
// sector field of bank 1
`define SECTOR_MSB           21
`define SECTOR_LSB           12
`define BOOT_SECTORS         8
// command codes on the host side
`define CMD_READ             3'h0
`define CMD_WRITE            3'h1
`define CMD_RESET            3'h2
`define CMD_ACCEL_ON         3'h3
`define CMD_ACCEL_OFF        3'h4

`endif

// ==== logic/flash_host_ctrl.v ====
// host-side controller driving an asynchronous parallel NOR flash
// assumes the flash pins are joined to these ports by the testbench
`timescale 1ns/1ps
`include "flash_host_map.vh"

module flash_host_ctrl #(
   parameter ADDR_W        = 22,
   parameter DATA_W        = 16,
   parameter RESET_RDY_CYC = `CEIL_CYC(`RESET_READY_EMB_NS)
) (
   input  wire              clock_in,
   input  wire              rst_in,
   input  wire              cmd_valid_in,
   input  wire [2:0]        cmd_op_in,
   input  wire [ADDR_W-1:0] cmd_addr_in,
   input  wire [DATA_W-1:0] cmd_wdata_in,
   input  wire              ready_busy_n_in,
   input  wire [DATA_W-1:0] dq_in,
   output reg               cmd_ready_out,
   output reg               rsp_valid_out,
   output reg  [DATA_W-1:0] rsp_rdata_out,
   output reg               interrupted_out,
   output reg  [9:0]        sector_out,
   output reg               boot_sector_out,
   output reg               chip_select_n_out,
   output reg               output_gate_n_out,
   output reg               write_strobe_n_out,
   output reg               reset_n_out,
   output reg  [ADDR_W-1:0] addr_out,
   output reg  [DATA_W-1:0] dq_out,
   output reg               dq_oe_n_out,
   output reg               write_protect_accel_pin_out,
   output reg               high_voltage_level_out
);

   // ---------------------------------------------------------------
   // state machine
   // ---------------------------------------------------------------
   localparam [6:0] S_IDLE  = 7'h01;
   localparam [6:0] S_READ  = 7'h02;
   localparam [6:0] S_WRITE = 7'h04;
   localparam [6:0] S_WHOLD = 7'h08;
   localparam [6:0] S_RSTLO = 7'h10;
   localparam [6:0] S_RSTRC = 7'h20;
   localparam [6:0] S_RSTHI = 7'h40;

   localparam integer CNT_W = 16;

   // 32-bit copies of the timing counts, cut to the counter width where loaded
   localparam [31:0] READ_W      = `READ_CYC;
   localparam [31:0] WRITE_W     = `WRITE_CYC;
   localparam [31:0] PULSE_W     = `RESET_PULSE_CYC;
   localparam [31:0] RDY_NON_W   = `RESET_READY_NON_CYC;
   localparam [31:0] RDY_EMB_W   = RESET_RDY_CYC;
   localparam [31:0] HIGH_READ_W = `RESET_HIGH_READ_CYC;

   reg [6:0]       state_r;
   reg [CNT_W-1:0] count_r;
   reg             busy_at_reset_r;
   reg             standby_r;

   wire [9:0] sector_sel = cmd_addr_in[`SECTOR_MSB:`SECTOR_LSB];

   always @(posedge clock_in) begin
      if (rst_in) begin
         state_r                     <= S_IDLE;
         count_r                     <= {CNT_W{1'b0}};
         busy_at_reset_r             <= 1'b0;
         standby_r                   <= 1'b1;
         cmd_ready_out               <= 1'b0;
         rsp_valid_out               <= 1'b0;
         rsp_rdata_out               <= {DATA_W{1'b0}};
         interrupted_out             <= 1'b0;
         sector_out                  <= 10'h000;
         boot_sector_out             <= 1'b0;
         chip_select_n_out           <= 1'b1;
         output_gate_n_out           <= 1'b1;
         write_strobe_n_out          <= 1'b1;
         reset_n_out                 <= 1'b1;
         addr_out                    <= {ADDR_W{1'b0}};
         dq_out                      <= {DATA_W{1'b0}};
         dq_oe_n_out                 <= 1'b1;
         write_protect_accel_pin_out <= 1'b1;
         high_voltage_level_out      <= 1'b0;
      end else begin
         rsp_valid_out <= 1'b0;
         case (state_r)
            S_IDLE: begin
               cmd_ready_out <= 1'b1;
               if (cmd_valid_in && cmd_ready_out) begin
                  cmd_ready_out <= 1'b0;
                  addr_out      <= cmd_addr_in;
                  // bank 1 sector decode for the user side
                  sector_out    <= sector_sel;
                  boot_sector_out <= (sector_sel < `BOOT_SECTORS);
                  case (cmd_op_in)
                     `CMD_READ: begin
                        chip_select_n_out <= 1'b0;
                        output_gate_n_out <= 1'b0;
                        // standby exit needs full chip-select access time
                        count_r   <= READ_W[CNT_W-1:0];
                        standby_r <= 1'b0;
                        // high voltage only ever rides on program cycles
                        high_voltage_level_out <= 1'b0;
                        state_r   <= S_READ;
                     end
                     `CMD_WRITE: begin
                        // one bus write cycle; callers build the sequences
                        chip_select_n_out  <= 1'b0;
                        output_gate_n_out  <= 1'b1;
                        write_strobe_n_out <= 1'b0;
                        dq_out      <= cmd_wdata_in;
                        dq_oe_n_out <= 1'b0;
                        count_r     <= WRITE_W[CNT_W-1:0];
                        standby_r   <= 1'b0;
                        state_r     <= S_WRITE;
                     end
                     `CMD_RESET: begin
                        busy_at_reset_r <= ~ready_busy_n_in;
                        interrupted_out <= ~ready_busy_n_in;
                        reset_n_out       <= 1'b0;
                        chip_select_n_out <= 1'b1;
                        output_gate_n_out <= 1'b1;
                        count_r <= PULSE_W[CNT_W-1:0];
                        high_voltage_level_out <= 1'b0;
                        state_r <= S_RSTLO;
                     end
                     `CMD_ACCEL_ON: begin
                        high_voltage_level_out <= 1'b1;
                        cmd_ready_out <= 1'b1;
                     end
                     `CMD_ACCEL_OFF: begin
                        high_voltage_level_out <= 1'b0;
                        cmd_ready_out <= 1'b1;
                     end
                     default: begin
                        cmd_ready_out <= 1'b1;
                     end
                  endcase
               end else if (!standby_r) begin
                  // idle: deselect, device carries on any embedded work
                  chip_select_n_out <= 1'b1;
                  output_gate_n_out <= 1'b1;
                  standby_r <= 1'b1;
               end
            end
            S_READ: begin
               if (count_r > 1) begin
                  count_r <= count_r - 1'b1;
               end else begin
                  rsp_rdata_out     <= dq_in;
                  rsp_valid_out     <= 1'b1;
                  output_gate_n_out <= 1'b1;
                  state_r           <= S_IDLE;
               end
            end
            S_WRITE: begin
               if (count_r > 1) begin
                  count_r <= count_r - 1'b1;
               end else begin
                  write_strobe_n_out <= 1'b1;
                  state_r <= S_WHOLD;
               end
            end
            S_WHOLD: begin
               // data held one cycle past the rising strobe
               dq_oe_n_out   <= 1'b1;
               rsp_valid_out <= 1'b1;
               state_r       <= S_IDLE;
            end
            S_RSTLO: begin
               if (count_r > 1) begin
                  count_r <= count_r - 1'b1;
               end else begin
                  reset_n_out <= 1'b1;
                  count_r <= busy_at_reset_r ? RDY_EMB_W[CNT_W-1:0]
                                             : RDY_NON_W[CNT_W-1:0];
                  state_r <= S_RSTRC;
               end
            end
            S_RSTRC: begin
               // wait for ready_busy_n_in to rise, leaving anyway when the recovery count runs out
               if (count_r > 1 && !ready_busy_n_in) begin
                  count_r <= count_r - 1'b1;
               end else begin
                  count_r <= HIGH_READ_W[CNT_W-1:0];
                  state_r <= S_RSTHI;
               end
            end
            S_RSTHI: begin
               if (count_r > 1) begin
                  count_r <= count_r - 1'b1;
               end else begin
                  rsp_valid_out <= 1'b1;
                  state_r       <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule // flash_host_ctrl

// ==== verif/flash_model.sv ====
// flash device model on the host pins; host clock stands in for its timer
`timescale 1ns/1ps
module flash_model (
   input  wire        clock_in, cs_n_in, oe_n_in, we_n_in, rst_n_in, hv_in,
   input  wire [21:0] addr_in,
   output wire [15:0] dq_out,
   output wire        ready_busy_n_out
);
   reg  [5:0]  busy_r = 6'h00;
   reg  [2:0]  acc_r = 3'h0;
   reg         we_q_r = 1'b1;
   reg         rst_q_r = 1'b1;
   reg  [15:0] last_r = 16'h0000;
   wire        drive = !cs_n_in && !oe_n_in && rst_n_in;
   assign ready_busy_n_out = (busy_r == 6'h00);
   // no pull on dq: early lines toggle each cycle, undriven lines hold the inverse of the last driven data
   assign dq_out = (drive && acc_r > 3'h5) ? addr_in[15:0] ^ 16'h5A5A
                                           : ~last_r;
   always @(posedge clock_in) begin
      we_q_r <= we_n_in;
      acc_r <= drive ? acc_r + (acc_r != 3'h7) : 3'h0;
      rst_q_r <= rst_n_in;
      if (drive) last_r <= dq_out;
      // an interrupted job's internal reset outlasts the reset pulse
      if (!rst_n_in && rst_q_r && busy_r != 6'h00) busy_r <= 6'h3C;
      else if (rst_n_in && we_n_in && !we_q_r) busy_r <= hv_in ? 6'h08 : 6'h28;
      else if (busy_r != 6'h00) busy_r <= busy_r - 6'h01;
   end
endmodule // flash_model

// ==== verif/flash_host_ctrl_checker.sv ====
// pin assertions for the flash host controller; assumes default widths
`timescale 1ns/1ps
module flash_host_ctrl_checker (
   input wire       clock_in, rst_in, rsp_valid_out, boot_sector_out,
   input wire       chip_select_n_out, output_gate_n_out, write_strobe_n_out,
   input wire       reset_n_out, dq_oe_n_out, write_protect_accel_pin_out, high_voltage_level_out,
   input wire [9:0] sector_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_we; !write_strobe_n_out [*4] ##1 write_strobe_n_out; endsequence
   property p_pin; write_protect_accel_pin_out; endproperty
   a_pin: assert property (p_pin) else $error("accel pin low");
   property p_rd; $fell(chip_select_n_out) && !output_gate_n_out |->
      !rsp_valid_out [*6] ##[1:2] rsp_valid_out; endproperty
   a_rd: assert property (p_rd) else $error("read timing");
   property p_oe; !output_gate_n_out |-> dq_oe_n_out; endproperty
   a_oe: assert property (p_oe) else $error("dq fight");
   property p_we; $fell(write_strobe_n_out) |-> s_we; endproperty
   a_we: assert property (p_we) else $error("write pulse");
   property p_ws; !write_strobe_n_out |-> !chip_select_n_out && output_gate_n_out; endproperty
   a_ws: assert property (p_ws) else $error("write strobes");
   property p_rp; $fell(reset_n_out) |-> ##49 !reset_n_out; endproperty
   a_rp: assert property (p_rp) else $error("reset pulse short");
   property p_rh; $rose(reset_n_out) |-> output_gate_n_out [*5]; endproperty
   a_rh: assert property (p_rh) else $error("early read");
   property p_boot; rsp_valid_out |-> boot_sector_out == (sector_out < 10'h008); endproperty
   a_boot: assert property (p_boot) else $error("boot flag");
   property p_hv; high_voltage_level_out |-> output_gate_n_out && reset_n_out; endproperty
   a_hv: assert property (p_hv) else $error("high voltage outside program");
endmodule // flash_host_ctrl_checker
bind flash_host_ctrl flash_host_ctrl_checker chk_i (.*);

// ==== verif/flash_host_ctrl_bench.sv ====
// bench: controller against the flash model; assumes the bound checker
`timescale 1ns/1ps
module flash_host_ctrl_bench;
   reg         clock_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0;
   reg  [2:0]  cmd_op_in = 3'h0;
   reg  [21:0] cmd_addr_in = 22'h000000;
   reg  [15:0] cmd_wdata_in = 16'h0000;
   wire        cmd_ready_out, rsp_valid_out, interrupted_out, boot_sector_out;
   wire        chip_select_n_out, output_gate_n_out, write_strobe_n_out, reset_n_out;
   wire        dq_oe_n_out, write_protect_accel_pin_out, high_voltage_level_out;
   wire        ready_busy_n_in;
   wire [9:0]  sector_out;
   wire [21:0] addr_out;
   wire [15:0] rsp_rdata_out, dq_out, dev_dq;
   wire [15:0] dq_in = dq_oe_n_out ? dev_dq : dq_out;
   integer     n_errors = 0, n_checks = 0, cyc = 0;
   flash_host_ctrl #(.RESET_RDY_CYC(20)) uut (.*);
   flash_model dev (.clock_in, .cs_n_in(chip_select_n_out), .oe_n_in(output_gate_n_out),
      .we_n_in(write_strobe_n_out), .rst_n_in(reset_n_out), .hv_in(high_voltage_level_out),
      .addr_in(addr_out), .dq_out(dev_dq), .ready_busy_n_out(ready_busy_n_in));
   initial forever #5 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 5000) n_errors++;
      if (cyc == 5000) stop_test;
   end
   task stop_test;
      if (n_errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input [47:0] nm, input [15:0] e, input [15:0] g);
      n_checks++;
      if (e !== g) n_errors++;
      if (e !== g) $display("MISMATCH %0s expected %h seen %h", nm, e, g);
   endtask
   // request held until an edge finds ready high
   task op(input [2:0] o, input [21:0] a, input w);
      cmd_op_in = o;
      cmd_addr_in = a;
      cmd_wdata_in = ~a[15:0];
      cmd_valid_in = 1'b1;
      while (cmd_ready_out !== 1'b1) @(posedge clock_in) #1;
      @(posedge clock_in) #1;
      cmd_valid_in = 1'b0;
      while (w && rsp_valid_out !== 1'b1) @(posedge clock_in) #1;
   endtask
   task t_read(input [21:0] a);
      op(3'h0, a, 1'b1);
      chk("rdata", a[15:0] ^ 16'h5A5A, rsp_rdata_out);
      chk("sector", a[21:12], sector_out);
      chk("boot", a[21:12] < 10'h008, boot_sector_out);
   endtask
   task t_accel;
      op(3'h3, 22'h000000, 1'b0);
      chk("hv", 1'b1, high_voltage_level_out);
      @(posedge clock_in) #1;
      op(3'h1, 22'h000555, 1'b1);
      op(3'h1, 22'h000100, 1'b1);
      chk("wdata", 16'hFEFF, dq_out);
      op(3'h4, 22'h000000, 1'b0);
      chk("hv", 1'b0, high_voltage_level_out);
      @(posedge clock_in) #1;
      op(3'h3, 22'h000000, 1'b0);
      @(posedge clock_in) #1;
      t_read(22'h000200);
      chk("hv", 1'b0, high_voltage_level_out);
      @(posedge clock_in) #1;
   endtask
   // reset hits a busy device first, then an idle one
   task t_reset;
      op(3'h1, 22'h020000, 1'b1);
      t_read(22'h200ABC);
      op(3'h2, 22'h000000, 1'b1);
      chk("intr", 1'b1, interrupted_out);
      chk("rdy", 1'b1, ready_busy_n_in);
      t_read(22'h000123);
      while (ready_busy_n_in !== 1'b1) @(posedge clock_in) #1;
      op(3'h2, 22'h000000, 1'b1);
      chk("intr", 1'b0, interrupted_out);
   endtask
   initial begin
      repeat (3) @(posedge clock_in);
      #1 rst_in = 1'b0;
      t_read(22'h000FFF);
      t_read(22'h007000);
      t_read(22'h008000);
      t_accel;
      t_reset;
      t_read(22'h3FF000);
      stop_test;
   end
endmodule // flash_host_ctrl_bench
